// ---- rtl/tzp_consts.svh ----
// Constants for the timer-zero prescaler block.
// Assumes inclusion by bare name from rtl/ files.
`ifndef TZP_CONSTS_SVH
`define TZP_CONSTS_SVH
`define TZP_COUNT_W      8
`define TZP_PRE_W        8
`define TZP_RATE_W       3
`define TZP_COUNT_RST    8'h00
`define TZP_COUNT_MAX    8'hFF
`define TZP_PRE_RST      8'h00
`define TZP_ASSIGN_TIMER 1'b0
`define TZP_ASSIGN_WDOG  1'b1
`define TZP_ONE_PRE      8'h01
`endif

// ---- rtl/tzp_pkg.sv ----
// Types shared by the timer-zero prescaler block.
// Assumes no other package.
package tzp_pkg;
  typedef enum logic [1:0] {
    TZP_SRC_INTERNAL,
    TZP_SRC_EXTERNAL
  } tzp_src_type;
endpackage : tzp_pkg

// ---- rtl/tzp_prescaler.sv ----
// Shared prescaler counter with rate-selected tap and clear.
// Assumes a single clock; increments arrive as same-domain pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tzp_consts.svh"
module tzp_prescaler #(
  parameter int PRE_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             inc,
  input  wire logic             clr,
  input  wire logic [2:0]       rate_sel,
  output logic                  tick,
  output logic [PRE_W-1:0]      count
);
  logic [PRE_W-1:0] count_q;
  logic [PRE_W-1:0] count_d;
  logic [PRE_W-1:0] mask;

  initial begin
    if (PRE_W != `TZP_PRE_W) $error("tzp_prescaler: PRE_W must be 8");
  end

  // Ratio 2^(n+1): a tick when the low n+1 bits roll over
  always_comb begin
    // Shift amount widened so rate 7 gives a full eight-bit mask
    mask = (`TZP_ONE_PRE << ({1'b0, rate_sel} + 4'h1)) - `TZP_ONE_PRE;
    tick = inc && ((count_q & mask) == mask);
    if (clr) begin
      count_d = `TZP_PRE_RST;
    end else if (inc) begin
      count_d = count_q + `TZP_ONE_PRE;
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TZP_PRE_RST;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule : tzp_prescaler
`default_nettype wire

// ---- rtl/tzp_timer.sv ----
// Operation
// - One prescaler, timer or watchdog, never both
// - Assign bit 0 timer, 1 watchdog
// - Timer ratios divide-by-2 through divide-by-256
// - Undivided count only when watchdog owns prescaler
// - Prescaler count not software accessible
// - Timer write clears prescaler when timer-assigned
// - Watchdog clear clears prescaler when watchdog-assigned
// - Overflow event on wrap from FFh to 00h
// - Flag sets on every wrap, enable ignored
// - Only software clears the overflow flag
// - Interrupt forwarded only while enable set
// - Count frozen in sleep; no wake
// - External pin synchronised, sampled in Q2/Q4
//
// Timer zero with shared prescaler and sticky overflow flag.
// Assumes the core supplies write strobes, sleep level and Q2/Q4 phase pulses.
`timescale 1ns/1ps
`default_nettype none
`include "tzp_consts.svh"
module tzp_timer #(
  parameter int COUNT_W = 8
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 prescaler_assign_sel,
  input  wire logic [2:0]           prescale_rate_sel,
  input  wire logic                 ext_clock_sel,
  input  wire logic                 ext_edge_falling,
  input  wire logic                 timer_zero_ext_clock_pin,
  input  wire logic                 q2_phase,
  input  wire logic                 q4_phase,
  input  wire logic                 sleep_mode,
  input  wire logic                 count_wr,
  input  wire logic [COUNT_W-1:0]   count_wr_data,
  input  wire logic                 flag_wr,
  input  wire logic                 flag_wr_data,
  input  wire logic                 timer_zero_irq_enable,
  input  wire logic                 watchdog_clear_instr,
  input  wire logic                 watchdog_tick,
  output logic [COUNT_W-1:0]        timer_zero_count,
  output logic                      timer_zero_overflow_flag,
  output logic                      timer_zero_irq,
  output logic                      watchdog_prescaled_tick,
  output logic                      watchdog_clear
);
  tzp_pkg::tzp_src_type src;
  logic                 pin_meta_q;
  logic                 pin_sync_q;
  logic                 pin_prev_q;
  logic                 ext_edge;
  logic                 ext_pend_q;
  logic                 ext_pend_d;
  logic                 ext_inc;
  logic                 base_inc;
  logic                 pre_inc;
  logic                 pre_clr;
  logic                 pre_tick;
  logic                 cnt_inc;
  logic [COUNT_W-1:0]   count_q;
  logic [COUNT_W-1:0]   count_d;
  logic                 flag_q;
  logic                 flag_d;
  logic                 wrap;

  initial begin
    if (COUNT_W != `TZP_COUNT_W) $error("tzp_timer: COUNT_W must be 8");
  end

  // Pin: two flops before any logic, then edge detect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
      ext_pend_q <= 1'b0;
    end else begin
      pin_meta_q <= timer_zero_ext_clock_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      ext_pend_q <= ext_pend_d;
    end
  end

  // Edges are held until the next Q2 or Q4 sample point
  always_comb begin
    src      = ext_clock_sel ? tzp_pkg::TZP_SRC_EXTERNAL : tzp_pkg::TZP_SRC_INTERNAL;
    ext_edge = ext_edge_falling ? (pin_prev_q & ~pin_sync_q) : (~pin_prev_q & pin_sync_q);
    ext_inc  = ext_pend_q && (q2_phase || q4_phase);
    if (ext_inc) begin
      ext_pend_d = ext_edge;
    end else begin
      ext_pend_d = ext_pend_q || ext_edge;
    end
  end

  // Prescaler ownership routing
  always_comb begin
    case (src)
      tzp_pkg::TZP_SRC_EXTERNAL: base_inc = ext_inc;
      tzp_pkg::TZP_SRC_INTERNAL: base_inc = 1'b1;
      default:                   base_inc = 1'b0;
    endcase
    if (prescaler_assign_sel == `TZP_ASSIGN_TIMER) begin
      pre_inc = base_inc && !sleep_mode;
      pre_clr = count_wr;
      cnt_inc = pre_tick && !sleep_mode;
    end else begin
      pre_inc = watchdog_tick;
      pre_clr = watchdog_clear_instr;
      cnt_inc = base_inc && !sleep_mode;
    end
  end

  // Prescaler count stays internal: no port exposes it
  tzp_prescaler #(
    .PRE_W    (`TZP_PRE_W)
  ) u_pre (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inc      (pre_inc),
    .clr      (pre_clr),
    .rate_sel (prescale_rate_sel),
    .tick     (pre_tick),
    .count    ()
  );

  // Count and sticky flag; an overflow beats a same-cycle software clear
  always_comb begin
    wrap = cnt_inc && !count_wr && (count_q == `TZP_COUNT_MAX);
    if (count_wr) begin
      count_d = count_wr_data;
    end else if (cnt_inc) begin
      count_d = count_q + 8'h01;
    end else begin
      count_d = count_q;
    end
    if (wrap) begin
      flag_d = 1'b1;
    end else if (flag_wr) begin
      flag_d = flag_wr_data;
    end else begin
      flag_d = flag_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `TZP_COUNT_RST;
      flag_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      flag_q  <= flag_d;
    end
  end

  assign timer_zero_count         = count_q;
  assign timer_zero_overflow_flag = flag_q;
  assign timer_zero_irq           = flag_q && timer_zero_irq_enable;
  assign watchdog_prescaled_tick  =
    (prescaler_assign_sel == `TZP_ASSIGN_WDOG) ? pre_tick : watchdog_tick;
  assign watchdog_clear           = watchdog_clear_instr;
endmodule : tzp_timer
`default_nettype wire

// ---- testbench/tzp_core_model.sv ----
// Core-side model: quarter-phase strobes and watchdog oscillator ticks.
// Assumes one clock shared with the timer.
`timescale 1ns/1ps
`default_nettype none
module tzp_core_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      q2_phase,
  output logic      q4_phase,
  output logic      watchdog_tick
);
  logic [3:0] ph_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ph_q <= 4'h0;
    else ph_q <= ph_q + 4'h1;
  end
  assign q2_phase      = ph_q[1:0] == 2'h1;
  assign q4_phase      = ph_q[1:0] == 2'h3;
  // Slow tick so a watchdog-owned prescaler moves rarely
  assign watchdog_tick = ph_q == 4'hF;
endmodule : tzp_core_model
`default_nettype wire

// ---- testbench/tzp_timer_checker.sv ----
// Port-level checks of the timer-zero block.
// Assumes binding onto tzp_timer with matching port names.
`timescale 1ns/1ps
`default_nettype none
module tzp_timer_checker (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       prescaler_assign_sel,
  input wire logic       ext_clock_sel,
  input wire logic       sleep_mode,
  input wire logic       count_wr,
  input wire logic [7:0] count_wr_data,
  input wire logic       flag_wr,
  input wire logic       flag_wr_data,
  input wire logic       timer_zero_irq_enable,
  input wire logic       watchdog_clear_instr,
  input wire logic [7:0] timer_zero_count,
  input wire logic       timer_zero_overflow_flag,
  input wire logic       timer_zero_irq,
  input wire logic       watchdog_clear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire run = !ext_clock_sel && !sleep_mode && !count_wr;
  sequence s_wrap;
    (timer_zero_count == 8'hFF && !count_wr) ##1 timer_zero_count == 8'h00;
  endsequence
  a_irq_gated: assert property (timer_zero_irq == (timer_zero_overflow_flag && timer_zero_irq_enable)) else $error("irq gating wrong");
  a_flag_sticky: assert property (timer_zero_overflow_flag && !(flag_wr && !flag_wr_data) |=> timer_zero_overflow_flag) else $error("flag lost");
  a_wrap_flag: assert property (s_wrap |-> timer_zero_overflow_flag) else $error("wrap without flag");
  a_sleep_hold: assert property (sleep_mode && !count_wr |=> $stable(timer_zero_count)) else $error("count moved in sleep");
  a_write_load: assert property (count_wr |=> timer_zero_count == $past(count_wr_data)) else $error("write not loaded");
  a_bypass_step: assert property (prescaler_assign_sel && run |=> timer_zero_count == $past(timer_zero_count) + 8'h01) else $error("bypass not 1:1");
  a_timer_divided: assert property ((!prescaler_assign_sel && run)[*3] |-> timer_zero_count != $past(timer_zero_count, 2) + 8'h02) else $error("timer undivided");
  a_wdclr_pass: assert property (watchdog_clear == watchdog_clear_instr) else $error("watchdog clear lost");
endmodule : tzp_timer_checker
bind tzp_timer tzp_timer_checker u_tzp_timer_checker (.*);
`default_nettype wire

// ---- testbench/test_tzp_timer.sv ----
// Self-checking bench for the timer-zero block.
// Assumes the core model supplies phases and watchdog ticks.
`timescale 1ns/1ps
`default_nettype none
module test_tzp_timer;
  logic clk_sys = 1'b0, rst_n = 1'b0, prescaler_assign_sel = 1'b0, sleep_mode = 1'b0;
  logic ext_clock_sel = 1'b0, ext_edge_falling = 1'b0, timer_zero_ext_clock_pin = 1'b0;
  logic count_wr = 1'b0, flag_wr = 1'b0, flag_wr_data = 1'b0, timer_zero_irq_enable = 1'b0;
  logic watchdog_clear_instr = 1'b0, q2_phase, q4_phase, watchdog_tick;
  logic [2:0] prescale_rate_sel = 3'h0;
  logic [7:0] count_wr_data = 8'h00, timer_zero_count;
  logic timer_zero_overflow_flag, timer_zero_irq, watchdog_prescaled_tick, watchdog_clear;
  int err_count = 0, comparisons = 0;
  tzp_timer u_tzp_timer (.*);
  tzp_core_model u_tzp_core_model (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tk
  task automatic wr_cnt(input logic [7:0] d);
    @(posedge clk_sys);
    count_wr <= 1'b1;
    count_wr_data <= d;
    @(posedge clk_sys);
    count_wr <= 1'b0;
  endtask : wr_cnt
  task automatic t_rates();
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      prescale_rate_sel <= 3'(n);
      wr_cnt(8'h00);
      tk(3 * (2 << n) + 1);
      chk(timer_zero_count, 8'h03);
    end
    $display("rates done");
  endtask : t_rates
  task automatic t_wrap();
    @(posedge clk_sys);
    prescaler_assign_sel <= 1'b1;
    wr_cnt(8'h10);
    tk(5);
    chk(timer_zero_count, 8'h15);
    wr_cnt(8'hFE);
    tk(2);
    chk(timer_zero_count, 8'h00);
    chk({7'h00, timer_zero_overflow_flag, timer_zero_irq}, 8'h02);
    @(posedge clk_sys);
    timer_zero_irq_enable <= 1'b1;
    watchdog_clear_instr <= 1'b1;
    tk(20);
    chk({6'h00, watchdog_clear, timer_zero_overflow_flag, timer_zero_irq}, 8'h07);
    watchdog_clear_instr <= 1'b0;
    flag_wr <= 1'b1;
    @(posedge clk_sys);
    flag_wr <= 1'b0;
    tk(1);
    chk({7'h00, timer_zero_overflow_flag, timer_zero_irq}, 8'h00);
    $display("wrap done");
  endtask : t_wrap
  task automatic t_sleep();
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    wr_cnt(8'h40);
    tk(10);
    chk(timer_zero_count, 8'h40);
    sleep_mode <= 1'b0;
    $display("sleep done");
  endtask : t_sleep
  task automatic pin_pulse();
    repeat (8) @(posedge clk_sys);
    timer_zero_ext_clock_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    timer_zero_ext_clock_pin <= 1'b0;
  endtask : pin_pulse
  task automatic t_ext();
    @(posedge clk_sys);
    prescaler_assign_sel <= 1'b1;
    ext_clock_sel <= 1'b1;
    ext_edge_falling <= 1'b0;
    wr_cnt(8'h00);
    repeat (3) pin_pulse();
    tk(8);
    chk(timer_zero_count, 8'h03);
    @(posedge clk_sys);
    ext_edge_falling <= 1'b1;
    repeat (3) pin_pulse();
    tk(8);
    chk(timer_zero_count, 8'h06);
    @(posedge clk_sys);
    ext_clock_sel <= 1'b0;
    ext_edge_falling <= 1'b0;
    $display("ext done");
  endtask : t_ext
  task automatic t_wdog();
    int n;
    n = 0;
    @(posedge clk_sys);
    prescaler_assign_sel <= 1'b1;
    prescale_rate_sel <= 3'h2;
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b1;
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b0;
    // Seven watchdog ticks after a clear never reach a divide-by-8 tick
    repeat (112) begin
      #1;
      if (watchdog_prescaled_tick === 1'b1) n++;
      @(posedge clk_sys);
    end
    chk(8'(n), 8'h00);
    repeat (16) begin
      #1;
      if (watchdog_prescaled_tick === 1'b1) n++;
      @(posedge clk_sys);
    end
    chk(8'(n), 8'h01);
    $display("watchdog done");
  endtask : t_wdog
  task automatic end_sim();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    tk(8);
    chk({6'h00, timer_zero_overflow_flag, timer_zero_irq}, 8'h00);
    chk(timer_zero_count, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_rates();
    t_wrap();
    t_sleep();
    t_ext();
    t_wdog();
    end_sim();
  end
  initial begin
    #200us;
    err_count++;
    end_sim();
  end
endmodule : test_tzp_timer
`default_nettype wire
